// ==== logic/rpc_reset_irq_pin_control.sv ====
// Reset sequencing, interrupt and warning pins, serial pin roles
`timescale 1ns/1ps
// How it works
// RL1 - Bits 7 and 8 choose second pulse quantity
// RL2 - Warning pin high only on checksum mismatch
// RL3 - Interrupt A follows any status A bit
// RL4 - Interrupt B follows any status B bit
// RL5 - Detection mode: detector drives, entry/exit clears
// RL6 - Stream runs exactly while enable input high
// RL7 - Host frames each register access with select
// RL8 - Device drives chip select while streaming
// RL9 - Serial out pin: output, input when streaming
// RL10 - Serial in pin: input, output when streaming
// RL11 - Low-power modes lose all but detection registers
// RL12 - Host rewrites configuration after low power
// RL13 - Oscillator off in idle and detection
// RL14 - Pin, power-on, software resets share scope
// RL15 - Reset pulses under 2 us ignored
// RL16 - Power-on reset at supply and regulator enable
// RL17 - Software reset works in normal mode
// RL18 - Reset clears all but harmonic ratio registers
// RL19 - Reset pin is active low
// RL20 - Synchronised counter filter on reset pin
module rpc_reset_irq_pin_control #(
    parameter int FILTER_CYCLES = rpc_pkg::RST_FILTER_CYCLES
) (
    input  wire logic                     clk_sys_i,
    input  wire logic                     rst_b_i,
    input  wire logic                     reset_pin_b_i,
    input  wire logic                     supply_good_i,
    input  wire logic                     soft_reset_wr_i,
    input  wire logic [3:0]               power_mode_i,
    input  wire logic [15:0]              metering_mode_cfg_a_i,
    input  wire logic                     cfg_wr_i,
    input  wire logic                     checksum_err_i,
    input  wire logic [15:0]              status_a_set_i,
    input  wire logic [15:0]              status_b_set_i,
    input  wire logic [15:0]              status_a_clr_i,
    input  wire logic [15:0]              status_b_clr_i,
    input  wire logic                     detector_i,
    input  wire logic                     reactive_pulse_i,
    input  wire logic                     arith_apparent_pulse_i,
    input  wire logic                     vector_apparent_pulse_i,
    input  wire logic                     stream_enable_i,
    input  wire logic                     stream_xfer_i,
    input  wire logic                     stream_data_i,
    input  wire logic                     reg_data_i,
    input  wire logic [1:0]               detect_cfg_idx_i,
    input  wire logic [15:0]              detect_cfg_wdata_i,
    input  wire logic                     detect_cfg_wr_i,
    output logic                          chip_reset_o,
    output logic                          osc_enable_o,
    output logic                          regulator_on_o,
    output logic                          reactive_apparent_pulse_o,
    output logic                          fatal_warning_out_o,
    output logic                          interrupt_out_a_o,
    output logic                          interrupt_out_b_o,
    output logic [15:0]                   system_event_status_a_o,
    output logic [15:0]                   system_event_status_b_o,
    output logic                          stream_active_o,
    output logic                          cs_o,
    output logic                          cs_oe_o,
    output logic                          serial_out_pin_o,
    output logic                          serial_out_pin_oe_o,
    output logic                          serial_in_pin_o,
    output logic                          serial_in_pin_oe_o,
    output logic [63:0]                   detect_cfg_o
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic                  pin_s1_q, pin_s2_q;
    logic [rpc_pkg::RST_CNT_W-1:0] flt_cnt_q, flt_cnt_d;
    logic                  pin_rst_q, pin_rst_d;
    logic                  supply_q;
    logic                  reg_on_prev_q;
    logic                  chip_rst_q, chip_rst_d;
    logic                  lowpwr;
    logic                  in_detect, det_prev_q;
    logic [15:0]           mmode_q, mmode_d;
    logic [15:0]           sta_q, sta_d, stb_q, stb_d;
    logic                  irqa_q, irqa_d, irqb_q, irqb_d;
    logic                  warn_q, pulse2_q, pulse2_d;
    logic                  stream_q, cs_q, cs_oe_q;
    logic                  sdo_q, sdo_oe_q, sdi_q, sdi_oe_q;
    logic [15:0]           dcfg_q [rpc_pkg::NUM_DETECT_CFG];

    assign lowpwr    = power_mode_i[0] | power_mode_i[1];
    assign in_detect = power_mode_i[1];

    // ----------------------------------------
    // Reset pin filter
    // ----------------------------------------
    // RL20 sync plus counter
    // RL15 short pulses ignored
    // RL19 low level requests reset
    always_comb begin
        flt_cnt_d = flt_cnt_q;
        pin_rst_d = pin_rst_q;
        if (pin_s2_q) begin
            flt_cnt_d = '0;
            pin_rst_d = 1'b0;
        end else if (int'(flt_cnt_q) >= FILTER_CYCLES - 1) begin
            pin_rst_d = 1'b1;
        end else begin
            flt_cnt_d = flt_cnt_q + 1'b1;
        end
    end

    // Second stage is the only reader of the first
    always_ff @(posedge clk_sys_i) begin
        pin_s1_q <= reset_pin_b_i;
        pin_s2_q <= pin_s1_q;
        if (!rst_b_i) begin
            flt_cnt_q <= '0;
            pin_rst_q <= 1'b0;
        end else begin
            flt_cnt_q <= flt_cnt_d;
            pin_rst_q <= pin_rst_d;
        end
    end

    // ----------------------------------------
    // Reset merge
    // ----------------------------------------
    // RL14 three sources one scope
    // RL16 supply rise and regulator enable
    // RL17 software reset only in normal mode
    always_comb begin
        chip_rst_d = pin_rst_q
                   | (supply_good_i & ~supply_q)
                   | (~lowpwr & ~reg_on_prev_q)
                   | (soft_reset_wr_i & power_mode_i[3]);
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            supply_q      <= 1'b0;
            reg_on_prev_q <= 1'b0;
            chip_rst_q    <= 1'b1;
        end else begin
            supply_q      <= supply_good_i;
            reg_on_prev_q <= ~lowpwr;
            chip_rst_q    <= chip_rst_d;
        end
    end

    // ----------------------------------------
    // Registers, interrupts, warning
    // ----------------------------------------
    // Set beats clear so no event is lost in the clearing cycle
    always_comb begin
        mmode_d  = cfg_wr_i ? metering_mode_cfg_a_i : mmode_q;
        sta_d    = (sta_q & ~status_a_clr_i) | status_a_set_i;
        stb_d    = (stb_q & ~status_b_clr_i) | status_b_set_i;
        // RL3 any status A bit, none while unpowered
        irqa_d   = (|sta_d) & ~lowpwr;
        // RL4 any status B bit
        irqb_d   = (|stb_d) & ~lowpwr;
        // RL5 detector in detection mode
        if (in_detect != det_prev_q) begin
            irqa_d = 1'b0;
            irqb_d = 1'b0;
        end else if (in_detect) begin
            irqa_d = detector_i;
            irqb_d = detector_i;
        end
        // RL1 select second pulse source
        if (mmode_q[rpc_pkg::PULSE2_VECTOR_BIT]) begin
            pulse2_d = vector_apparent_pulse_i;
        end else if (mmode_q[rpc_pkg::PULSE2_REACTIVE_BIT]) begin
            pulse2_d = arith_apparent_pulse_i;
        end else begin
            pulse2_d = reactive_pulse_i;
        end
    end

    // RL11 context lost in low power
    // RL18 general state cleared by every reset
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || chip_rst_q || lowpwr) begin
            mmode_q  <= rpc_pkg::CFG_RST_VAL;
            sta_q    <= rpc_pkg::STATUS_RST_VAL;
            stb_q    <= rpc_pkg::STATUS_RST_VAL;
            pulse2_q <= 1'b0;
            warn_q   <= 1'b0;
        end else begin
            mmode_q  <= mmode_d;
            sta_q    <= sta_d;
            stb_q    <= stb_d;
            pulse2_q <= pulse2_d;
            // RL2 warning mirrors checksum fault
            warn_q   <= checksum_err_i;
        end
    end

    // Interrupt pins keep running in detection mode
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || chip_rst_q) begin
            irqa_q     <= 1'b0;
            irqb_q     <= 1'b0;
            det_prev_q <= 1'b0;
        end else begin
            irqa_q     <= irqa_d;
            irqb_q     <= irqb_d;
            det_prev_q <= in_detect;
        end
    end

    // Detection configuration survives low power, cleared only by reset
    genvar gi;
    generate
        for (gi = 0; gi < rpc_pkg::NUM_DETECT_CFG; gi++) begin : g_dcfg
            always_ff @(posedge clk_sys_i) begin
                if (!rst_b_i || chip_rst_q) begin
                    dcfg_q[gi] <= rpc_pkg::CFG_RST_VAL;
                end else if (detect_cfg_wr_i && detect_cfg_idx_i == 2'(gi)) begin
                    dcfg_q[gi] <= detect_cfg_wdata_i;
                end
            end
            assign detect_cfg_o[gi*16 +: 16] = dcfg_q[gi];
        end
    endgenerate

    // ----------------------------------------
    // Serial pin roles
    // ----------------------------------------
    // RL6 stream follows enable
    // RL8 device drives select while streaming
    // RL9 out pin direction
    // RL10 in pin direction
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i || chip_rst_q || lowpwr) begin
            stream_q <= 1'b0;
            cs_q     <= 1'b1;
            cs_oe_q  <= 1'b0;
            sdo_q    <= 1'b0;
            sdo_oe_q <= 1'b0;
            sdi_q    <= 1'b0;
            sdi_oe_q <= 1'b0;
        end else begin
            stream_q <= stream_enable_i;
            cs_q     <= ~(stream_enable_i & stream_xfer_i);
            cs_oe_q  <= stream_enable_i;
            sdo_q    <= reg_data_i;
            sdo_oe_q <= ~stream_enable_i;
            sdi_q    <= stream_data_i;
            sdi_oe_q <= stream_enable_i;
        end
    end

    // RL13 oscillator off in low power
    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            osc_enable_o   <= 1'b0;
            regulator_on_o <= 1'b0;
        end else begin
            osc_enable_o   <= ~lowpwr;
            regulator_on_o <= ~lowpwr;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign chip_reset_o              = chip_rst_q;
    assign reactive_apparent_pulse_o = pulse2_q;
    assign fatal_warning_out_o       = warn_q;
    assign interrupt_out_a_o         = irqa_q;
    assign interrupt_out_b_o         = irqb_q;
    assign system_event_status_a_o   = sta_q;
    assign system_event_status_b_o   = stb_q;
    assign stream_active_o           = stream_q;
    assign cs_o                      = cs_q;
    assign cs_oe_o                   = cs_oe_q;
    assign serial_out_pin_o          = sdo_q;
    assign serial_out_pin_oe_o       = sdo_oe_q;
    assign serial_in_pin_o           = sdi_q;
    assign serial_in_pin_oe_o        = sdi_oe_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    AST_WARN_FOLLOWS: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RL2
        (!chip_rst_q && !lowpwr) |=> (fatal_warning_out_o == $past(checksum_err_i)))
        else $error("warning pin does not follow checksum fault");
    AST_IRQA_STATUS: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RL3
        (!in_detect && !det_prev_q && !lowpwr && !chip_rst_q) |-> ##1
        (interrupt_out_a_o == (|system_event_status_a_o)))
        else $error("interrupt A not matching status A");
    AST_IRQB_STATUS: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RL4
        (!in_detect && !det_prev_q && !lowpwr && !chip_rst_q) |-> ##1
        (interrupt_out_b_o == (|system_event_status_b_o)))
        else $error("interrupt B not matching status B");
    AST_DET_CLEAR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RL5
        (in_detect != det_prev_q) |=> (!interrupt_out_a_o && !interrupt_out_b_o))
        else $error("interrupts not cleared on detection change");
    AST_STREAM: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RL6
        (!chip_rst_q && !lowpwr) |=> (stream_active_o == $past(stream_enable_i)))
        else $error("stream state wrong");
    AST_PIN_DIR: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RL9
        serial_out_pin_oe_o |-> !serial_in_pin_oe_o && !cs_oe_o)
        else $error("serial pins driven together");
    AST_OSC_OFF: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RL13
        lowpwr |=> !osc_enable_o)
        else $error("oscillator on in low power");
    AST_SHORT_GLITCH: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RL15
        (pin_s2_q ##1 !pin_s2_q [*4] ##1 pin_s2_q) |-> !pin_rst_q)
        else $error("short reset pulse accepted");
    AST_SOFT_RESET: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RL17
        (soft_reset_wr_i && power_mode_i[3]) |=> chip_reset_o)
        else $error("software reset lost");
    AST_LOWPWR_CTX: assert property (@(posedge clk_sys_i) disable iff (!rst_b_i) // RL11
        lowpwr |=> (system_event_status_a_o == rpc_pkg::STATUS_RST_VAL))
        else $error("context kept in low power");

    COV_STREAM: cover property (@(posedge clk_sys_i) stream_enable_i ##1 stream_active_o);
    COV_PIN_RST: cover property (@(posedge clk_sys_i) pin_rst_q);
    COV_DETECT: cover property (@(posedge clk_sys_i) in_detect && interrupt_out_a_o);
endmodule

// ==== logic/rpc_pkg.sv ====
// Package: constants and types for the reset, interrupt and pin control block
package rpc_pkg;
    // ----------------------------------------
    // Register offsets and field positions
    // ----------------------------------------
    localparam logic [7:0] SYS_EVENT_STATUS_A_OFS = 8'h01;
    localparam logic [7:0] SYS_EVENT_STATUS_B_OFS = 8'h02;
    localparam logic [7:0] DETECT_CFG_FIRST_OFS   = 8'h10;
    localparam logic [7:0] DETECT_CFG_LAST_OFS    = 8'h13;
    localparam int         PULSE2_REACTIVE_BIT    = 7;
    localparam int         PULSE2_VECTOR_BIT      = 8;
    localparam logic [15:0] STATUS_RST_VAL        = 16'h0000;
    localparam logic [15:0] CFG_RST_VAL           = 16'h0000;
    localparam int          REG_W                 = 16;
    localparam int          NUM_DETECT_CFG        = 4;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    localparam int RST_FILTER_NS     = 2000;
    localparam int RST_FILTER_CYCLES = (RST_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W         = 9;

    // ----------------------------------------
    // Power modes (one-hot)
    // ----------------------------------------
    typedef enum logic [3:0] {
        RPC_PM_IDLE    = 4'b0001,
        RPC_PM_DETECT  = 4'b0010,
        RPC_PM_PARTIAL = 4'b0100,
        RPC_PM_NORMAL  = 4'b1000
    } rpc_pmode_e;
endpackage

// ==== tb/rpc_host_model.sv ====
// Host model: owns chip select outside streaming and resolves the shared pin
`timescale 1ns/1ps
module rpc_host_model (
    input  wire logic clk_sys_i,
    input  wire logic frame_req_i,
    input  wire logic dev_cs_i,
    input  wire logic dev_cs_oe_i,
    output logic      cs_wire_o
);
    logic host_cs_q;
    // framed register access
    // Select falls one cycle after the frame request rises and rises one cycle after it drops
    always_ff @(posedge clk_sys_i) begin
        host_cs_q <= ~frame_req_i;
    end
    // device owns select
    // Host lets go while the device drives, so the wire never sees two drivers
    assign cs_wire_o = dev_cs_oe_i ? dev_cs_i : host_cs_q;
endmodule

// ==== tb/rpc_reset_irq_pin_control_tb_top.sv ====
// Testbench for the reset, interrupt and pin control block
`timescale 1ns/1ps
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin n_fail++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module rpc_reset_irq_pin_control_tb_top;
    localparam int FC = 8;
    logic clk_sys_i = 0, rst_b_i = 0, pin_b = 1, sup = 1, swr = 0, cfg_wr = 0;
    logic [3:0] pm = rpc_pkg::RPC_PM_NORMAL;
    logic [15:0] cfg = 0, sa = 0, sb = 0, ca = 0, cb = 0, dcw = 0;
    logic cks = 0, det = 0, rp = 0, ap = 0, vp = 0, sen = 0, sx = 0, sd = 0, rd = 0;
    logic [1:0] dci = 0;
    logic dcwr = 0, frame = 0, seen, cs_w;
    logic crst, osc, regon, p2, warn, irqa, irqb, sact, cs, cs_oe, so, so_oe, si, si_oe;
    logic [15:0] sta, stb;
    logic [63:0] dcfg;
    int n_fail = 0, cmp_count = 0, cyc_n = 0;
    // Clock at 100 MHz
    always #5 clk_sys_i = ~clk_sys_i;
    rpc_reset_irq_pin_control #(.FILTER_CYCLES(FC)) dut_u (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .reset_pin_b_i(pin_b),
        .supply_good_i(sup), .soft_reset_wr_i(swr), .power_mode_i(pm),
        .metering_mode_cfg_a_i(cfg), .cfg_wr_i(cfg_wr), .checksum_err_i(cks),
        .status_a_set_i(sa), .status_b_set_i(sb), .status_a_clr_i(ca),
        .status_b_clr_i(cb), .detector_i(det), .reactive_pulse_i(rp),
        .arith_apparent_pulse_i(ap), .vector_apparent_pulse_i(vp),
        .stream_enable_i(sen), .stream_xfer_i(sx), .stream_data_i(sd), .reg_data_i(rd),
        .detect_cfg_idx_i(dci), .detect_cfg_wdata_i(dcw), .detect_cfg_wr_i(dcwr),
        .chip_reset_o(crst), .osc_enable_o(osc), .regulator_on_o(regon),
        .reactive_apparent_pulse_o(p2), .fatal_warning_out_o(warn),
        .interrupt_out_a_o(irqa), .interrupt_out_b_o(irqb),
        .system_event_status_a_o(sta), .system_event_status_b_o(stb),
        .stream_active_o(sact), .cs_o(cs), .cs_oe_o(cs_oe), .serial_out_pin_o(so),
        .serial_out_pin_oe_o(so_oe), .serial_in_pin_o(si), .serial_in_pin_oe_o(si_oe),
        .detect_cfg_o(dcfg));
    rpc_host_model host_u (.clk_sys_i(clk_sys_i), .frame_req_i(frame),
        .dev_cs_i(cs), .dev_cs_oe_i(cs_oe), .cs_wire_o(cs_w));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic cy(input int n);
        repeat (n) @(negedge clk_sys_i);
    endtask
    // Notes whether chip reset shows at any point in the next n cycles
    task automatic watch(input int n);
        seen = 0;
        repeat (n) begin
            cy(1);
            if (crst === 1'b1) seen = 1;
        end
    endtask
    task automatic summarize;
        $display("cmp_count=%0d n_fail=%0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Hang guard: far beyond the roughly 150 cycles the tests need
    always @(posedge clk_sys_i) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            n_fail++;
            summarize();
        end
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Every select code routes its own source, others stay out
    task automatic t_pulse_sel;
        for (int i = 0; i < 4; i++) begin
            cfg = 16'(i) << 7; cfg_wr = 1; cy(1); cfg_wr = 0;
            {vp, ap, rp} = i[1] ? 3'b100 : (i[0] ? 3'b010 : 3'b001); cy(2);
            `CHK(p2, 1'b1)
            {vp, ap, rp} = ~{vp, ap, rp}; cy(2);
            `CHK(p2, 1'b0)
        end
        {vp, ap, rp} = 0;
    endtask
    task automatic t_warn_irq;
        cks = 1; cy(2); `CHK(warn, 1'b1)
        cks = 0; cy(2); `CHK(warn, 1'b0)
        sa = 16'h0008; sb = 16'h8000; cy(1); sa = 0; sb = 0; cy(2);
        `CHK({irqa, irqb}, 2'b11)
        ca = 16'h0008; cy(1); ca = 0; cy(2);
        `CHK({irqa, irqb}, 2'b01)
        cb = 16'h8000; cy(1); cb = 0; cy(2);
        `CHK(irqb, 1'b0)
        // A set in the clearing cycle must survive
        sa = 16'h0002; cy(1); ca = 16'h0002; cy(1); sa = 0; ca = 0; cy(1);
        `CHK(sta, 16'h0002)
        ca = 16'h0002; cy(1); ca = 0; cy(1);
        `CHK({sta, irqa}, 17'h0_0000)
    endtask
    // Low power drops context but keeps detection config; wake gives power-on reset
    task automatic t_detect;
        sa = 16'h0001; cy(1); sa = 0;
        dci = 2; dcw = 16'ha5a5; dcwr = 1; det = 1; cy(1); dcwr = 0;
        // Interrupt A stands high from status, so only the entry clear drops it
        pm = rpc_pkg::RPC_PM_DETECT; cy(1);
        `CHK({irqa, irqb}, 2'b00)
        cy(2);
        `CHK({osc, regon}, 2'b00)
        `CHK(sta, 16'h0000)
        `CHK(dcfg[47:32], 16'ha5a5)
        `CHK({irqa, irqb}, 2'b11)
        det = 0; cy(2); `CHK({irqa, irqb}, 2'b00)
        pm = rpc_pkg::RPC_PM_NORMAL; watch(4);
        `CHK(seen, 1'b1)
        cy(3); `CHK({osc, regon}, 2'b11)
        // Vector select from before sleep is gone, so reactive drives again
        {vp, ap, rp} = 3'b001; cy(2); `CHK(p2, 1'b1)
        cfg = 16'h0100; cfg_wr = 1; cy(1); cfg_wr = 0;
        {vp, ap, rp} = 3'b100; cy(2); `CHK(p2, 1'b1)
        {vp, ap, rp} = 0;
        // Idle drops status and interrupt and stops the oscillator too
        sa = 16'h0004; cy(1); sa = 0;
        pm = rpc_pkg::RPC_PM_IDLE; cy(2);
        `CHK({osc, regon}, 2'b00)
        `CHK(sta, 16'h0000)
        `CHK(irqa, 1'b0)
        pm = rpc_pkg::RPC_PM_NORMAL; watch(4); `CHK(seen, 1'b1)
        cy(2);
    endtask
    task automatic t_stream;
        frame = 1; rd = 1; cy(2); `CHK(cs_w, 1'b0)
        `CHK({so, so_oe}, 2'b11)
        frame = 0; rd = 0; cy(2); `CHK(cs_w, 1'b1)
        `CHK(so, 1'b0)
        sen = 1; sx = 1; sd = 1; cy(2);
        `CHK({si, si_oe}, 2'b11)
        `CHK({sact, cs_oe, si_oe, so_oe}, 4'b1110)
        `CHK(cs_w, 1'b0)
        sx = 0; cy(2); `CHK(cs_w, 1'b1)
        sen = 0; sd = 0; cy(2);
        `CHK({sact, cs_oe, si_oe}, 3'b000)
    endtask
    // Soft reset refused in partial mode, honoured in normal mode
    task automatic t_soft;
        pm = rpc_pkg::RPC_PM_PARTIAL; cy(3);
        swr = 1; watch(1); swr = 0; `CHK(seen, 1'b0)
        watch(6); `CHK(seen, 1'b0)
        pm = rpc_pkg::RPC_PM_NORMAL; cy(3);
        sb = 16'h0100; cy(1); sb = 0;
        // Reset stands one cycle, right after the write edge
        swr = 1; watch(1); swr = 0; `CHK(seen, 1'b1)
        cy(3); `CHK(stb, 16'h0000)
    endtask
    // Short pin glitch ignored; long low resets and clears state
    task automatic t_pin_sup;
        pin_b = 0; cy(FC / 2); pin_b = 1; watch(FC + 6);
        `CHK(seen, 1'b0)
        sa = 16'h0040; cy(1); sa = 0;
        pin_b = 0; watch(FC + 6); pin_b = 1;
        `CHK(seen, 1'b1)
        cy(4); `CHK(sta, 16'h0000)
        sup = 0; cy(3); sup = 1; watch(4);
        `CHK(seen, 1'b1)
        cy(4);
    endtask
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        cy(5);
        rst_b_i = 1;
        cy(6);
        t_pulse_sel();
        t_warn_irq();
        t_detect();
        t_stream();
        t_soft();
        t_pin_sup();
        summarize();
    end
endmodule
